// ===== src/ramp_pkg.sv
// Purpose: Shared constants for the slew-rate ramp controller.
// Assumes: 20 MHz system clock, 32-bit Avalon-MM slave with byte addresses.
// Notes: Slopes are hundredths of output units per second.
package ramp_pkg;
    // Clock and tick timing
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES_DOC = (CLK_HZ / 1_000_000) * TICK_PERIOD_US;
    localparam int WDOG_TICKS_PER_MIN_DOC = 60_000;

    // Datapath widths
    localparam int DAC_W = 12;
    localparam int FRAC_W = 20;
    localparam int ACC_W = DAC_W + FRAC_W;
    localparam int SLOPE_W = 24;
    localparam int GAIN_W = 20;
    localparam int GAIN_SHIFT = 16;
    localparam int WDOG_W = 32;
    localparam int PRESET_W = 8;
    localparam int IN_W = 4;

    // Slope limits in hundredths: 0.01 and 99999.99 (the step value)
    localparam logic [SLOPE_W-1:0] SLOPE_MIN = 24'h000001;
    localparam logic [SLOPE_W-1:0] SLOPE_STEP = 24'h98967F;
    localparam logic [SLOPE_W-1:0] SLOPE_RESET = 24'h0186A0;

    // Full scale of the output in hundredths of a unit (10000.00)
    localparam longint FULL_SCALE_CENTI = 1_000_000;
    localparam longint TICKS_PER_S = 1000;
    localparam logic [GAIN_W-1:0] SLOPE_GAIN = GAIN_W'((64'h1 << (ACC_W + GAIN_SHIFT))
        / (FULL_SCALE_CENTI * TICKS_PER_S));
    localparam logic [ACC_W-1:0] ROUND_HALF = 32'h0008_0000;
    localparam logic [FRAC_W-1:0] FRAC_ZERO = 20'h00000;
    localparam logic [DAC_W-1:0] CODE_MAX = 12'hFFF;
    localparam logic [DAC_W-1:0] CODE_MIN = 12'h000;

    // Reset values
    localparam logic [DAC_W-1:0] START_RESET = 12'h000;
    localparam logic [PRESET_W-1:0] WDOG_PRESET_RESET = 8'h00;

    // Register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_TARGET = 6'h04;
    localparam logic [5:0] OFS_SLOPE_TEMP = 6'h08;
    localparam logic [5:0] OFS_SLOPE_PERSIST = 6'h0C;
    localparam logic [5:0] OFS_WORK_SLOPE = 6'h10;
    localparam logic [5:0] OFS_STORED_SLOPE = 6'h14;
    localparam logic [5:0] OFS_DAC_CODE = 6'h18;
    localparam logic [5:0] OFS_STATUS = 6'h1C;
    localparam logic [5:0] OFS_WDOG_PRESET = 6'h20;
    localparam logic [5:0] OFS_START_VALUE = 6'h24;

    // Field positions
    localparam int CTRL_WE_BIT = 0;
    localparam int CTRL_RESET_BIT = 1;
    localparam int ST_AT_TARGET_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_WDOG_BIT = 2;
    localparam int ST_WE_BIT = 3;
    localparam int ST_IN_LSB = 4;
    localparam int IN_UP = 3;
    localparam int IN_DN = 2;
    localparam int IN_LIM_HI = 1;
    localparam int IN_LIM_LO = 0;
endpackage : ramp_pkg

// ===== src/slew_ramp_ctrl.sv
// Purpose: Slew-rate ramp controller for a 12-bit output converter.
// Assumes: Single 20 MHz clock; registers reached over Avalon-MM with waitrequest.
// Notes: Input scaling, calibration and command parsing live elsewhere.
// Notes on behaviour
// - Slopes 0.01 to 99999.99 per second; the top value steps straight to target.
// - Slopes are volts or milliamps per second; slope writes need write enable first.
// - While ramping, update the converter once every 1 ms tick.
// - Add the signed slope increment to a fine accumulator before each update.
// - Round the accumulator to the nearest 12-bit code and drive it out.
// - Keep stepping each tick until output equals latest target, then stop.
// - Ramp increments always come from the working slope copy.
// - Power-up and remote reset load working slope from the stored slope.
// - Persistent slope write updates both stored and working slopes.
// - Temporary slope write updates only the working slope.
// - Working slope read returns the working copy.
// - Stored slope read returns the stored copy.
// - Ramping runs in background; other accesses do not disturb it.
// - New target mid-ramp replaces target at once; ramp may reverse.
// - Slope write mid-ramp takes effect at once toward existing target.
// - Remote reset stops any ramp and holds the present output.
// - Watchdog timeout takes over the output even mid-ramp.
// - Manual and limit inputs override host targets when active.
// - Output read returns the code being driven, intermediate values included.
// - Status read reports whether output has reached the final target.
// - Watchdog expiry sets target to starting value, slewing at present slope.
// - Every valid access clears and restarts the watchdog count.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
module slew_ramp_ctrl
    import ramp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DOC,
    parameter int WDOG_TICKS_PER_MIN = WDOG_TICKS_PER_MIN_DOC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Front panel pins, asynchronous
    input wire logic man_up,
    input wire logic man_dn,
    input wire logic lim_hi,
    input wire logic lim_lo,
    // Converter
    output logic [DAC_W-1:0] dac_code,
    output logic dac_update,
    output logic at_target
);
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [14:0] tick_cnt;
        logic [IN_W-1:0] in_meta;
        logic [IN_W-1:0] in_sync;
        logic man_prev;
        logic we;
        logic refused;
        logic wdog_fired;
        logic [WDOG_W-1:0] wdog_cnt;
        logic [PRESET_W-1:0] wdog_preset;
        logic [DAC_W-1:0] start_val;
        logic [SLOPE_W-1:0] slope_work;
        logic [SLOPE_W-1:0] slope_stored;
        logic [DAC_W-1:0] target;
        logic [ACC_W-1:0] acc;
        logic [DAC_W-1:0] dac;
        logic dac_strobe;
        logic done;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);
    localparam logic [WDOG_W-1:0] WDOG_PER_MIN = WDOG_W'(WDOG_TICKS_PER_MIN);

    // Register map, byte offsets
    //   0x00 control: bit 0 arms one slope write, bit 1 reset
    //   0x04 host target code
    //   0x08 temporary slope, working copy only
    //   0x0C persistent slope, both copies
    //   0x10 working slope read
    //   0x14 stored slope read
    //   0x18 code now driven
    //   0x1C status: at target, refused, fired, enable, pins
    //   0x20 watchdog preset in minutes, zero is off
    //   0x24 starting value code
    // Unmapped offsets read zero and ignore writes.

    // Bus timing
    //   Each request costs two clocks, waitrequest high then low.
    //   Writes act at the edge that ends the low cycle.
    //   A request still high after it starts a new transfer,
    //   so the master drops it at the answering edge.
    //   Read data stands until the next answer.

    // Accumulator
    //   Twelve integer bits hold the code.
    //   Twenty fraction bits gather slow steps.
    //   A narrow fraction would stall the slowest ramps.
    //   The value stays within 0.0 to 4095.0, no carry out.

    // Slope scaling
    //   Slopes are hundredths of a unit per second.
    //   Full scale is 10000.00 units over 4096 codes.
    //   One multiply and shift replaces a divider.
    //   The truncated gain runs long ramps a hair slow;
    //   the clamp hides this at the end point.
    //   The top slope skips the multiply and lands at once.

    // Tick
    //   A free counter gives one tick per millisecond.
    //   The strobe pulses every tick, moving or not,
    //   so a downstream latch sees an even rate.
    //   Bus traffic never shifts the tick.

    // Step and clamp
    //   Each tick compares accumulator and target.
    //   Within one step, the target itself is taken,
    //   so the ramp cannot overshoot.
    //   Otherwise one step is added or removed.
    //   A new target only changes the comparison,
    //   so a ramp may turn round without a pause.
    //   A new slope only changes the step size,
    //   so the rate changes at the next tick.

    // Remote reset
    //   Reloads the working slope from the stored one.
    //   Freezes target and accumulator at the driven code.
    //   The gathered fraction is dropped; harmless,
    //   as the output already shows the rounded code.
    //   The enable bit in the same word is kept as written.

    // Write protection
    //   One enable arms exactly one slope write.
    //   The attempt consumes it, in range or not.
    //   A refused write leaves both copies alone
    //   and sets a sticky flag, cleared by writing one.

    // Front panel pins
    //   Synchronised first, so they act 2 to 3 clocks late.
    //   Up wins over down.
    //   While held, the host target is shadowed but kept.
    //   On release the target becomes the present code,
    //   so the output holds instead of sliding back.
    //   Limit pins only block steps in their direction;
    //   they never move the output themselves.

    // Watchdog
    //   Counts ticks while the bus is quiet.
    //   Any completed access clears count and flag.
    //   On expiry the target becomes the starting value,
    //   reached at the working slope.
    //   The flag stops the count until the host returns,
    //   so the target is not forced again and again.

    // Limitations
    //   The stored copy sits in flip-flops and powers up
    //   at its default instead of loading from storage.
    //   Scaling, trims and command text live elsewhere.
    //   Status compares against the host target only.

    // Nearest code: add one half LSB then truncate; acc never exceeds 4095.0
    function automatic logic [DAC_W-1:0] round_code(input logic [ACC_W-1:0] a);
        logic [ACC_W-1:0] s;
        s = a + ROUND_HALF;
        return s[ACC_W-1:FRAC_W];
    endfunction : round_code

    function automatic logic [ACC_W-1:0] code_to_acc(input logic [DAC_W-1:0] c);
        return {c, FRAC_ZERO};
    endfunction : code_to_acc

    // Per-tick step in accumulator units, from slope in hundredths per second
    function automatic logic [ACC_W-1:0] step_of(input logic [SLOPE_W-1:0] s);
        logic [SLOPE_W+GAIN_W-1:0] p;
        p = s * SLOPE_GAIN;
        return ACC_W'(p >> GAIN_SHIFT);
    endfunction : step_of

    function automatic logic slope_ok(input logic [31:0] d);
        return (d[31:SLOPE_W] == 8'h00) && (d[SLOPE_W-1:0] >= SLOPE_MIN)
            && (d[SLOPE_W-1:0] <= SLOPE_STEP);
    endfunction : slope_ok

    always_comb begin
        logic take;
        logic access;
        logic tick;
        logic man_on;
        logic [DAC_W-1:0] eff_tgt;
        logic [ACC_W-1:0] tgt_acc;
        logic [ACC_W-1:0] step;
        logic is_step;
        take = 1'b0;
        access = 1'b0;
        tick = 1'b0;
        man_on = 1'b0;
        eff_tgt = CODE_MIN;
        tgt_acc = '0;
        step = '0;
        is_step = 1'b0;
        st_nxt = st_r;
        st_nxt.dac_strobe = 1'b0;

        // Pins pass two flops before use
        st_nxt.in_meta = {man_up, man_dn, lim_hi, lim_lo};
        st_nxt.in_sync = st_r.in_meta;

        // One wait cycle, then answer with waitrequest low for one cycle
        st_nxt.waitreq = 1'b1;
        if ((read || write) && st_r.waitreq) begin
            st_nxt.waitreq = 1'b0;
            st_nxt.rdata = 32'h0000_0000;
            if (read) begin
                case (address)
                    OFS_CTRL: st_nxt.rdata[CTRL_WE_BIT] = st_r.we;
                    OFS_TARGET: st_nxt.rdata[DAC_W-1:0] = st_r.target;
                    OFS_WORK_SLOPE: st_nxt.rdata[SLOPE_W-1:0] = st_r.slope_work;
                    OFS_STORED_SLOPE: st_nxt.rdata[SLOPE_W-1:0] = st_r.slope_stored;
                    OFS_DAC_CODE: st_nxt.rdata[DAC_W-1:0] = st_r.dac;
                    OFS_STATUS: begin
                        st_nxt.rdata[ST_AT_TARGET_BIT] = st_r.done;
                        st_nxt.rdata[ST_REFUSED_BIT] = st_r.refused;
                        st_nxt.rdata[ST_WDOG_BIT] = st_r.wdog_fired;
                        st_nxt.rdata[ST_WE_BIT] = st_r.we;
                        st_nxt.rdata[ST_IN_LSB +: IN_W] = st_r.in_sync;
                    end
                    OFS_WDOG_PRESET: st_nxt.rdata[PRESET_W-1:0] = st_r.wdog_preset;
                    OFS_START_VALUE: st_nxt.rdata[DAC_W-1:0] = st_r.start_val;
                    default: st_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
        access = (read || write) && !st_r.waitreq;
        take = write && !st_r.waitreq;

        // Free-running 1 ms tick
        if (st_r.tick_cnt == TICK_LAST) begin
            st_nxt.tick_cnt = '0;
            tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 15'h0001;
        end

        // Manual inputs take over the target; on release hold where we are
        man_on = st_r.in_sync[IN_UP] || st_r.in_sync[IN_DN];
        st_nxt.man_prev = man_on;
        eff_tgt = st_r.target;
        if (st_r.in_sync[IN_UP]) begin
            eff_tgt = CODE_MAX;
        end else if (st_r.in_sync[IN_DN]) begin
            eff_tgt = CODE_MIN;
        end
        if (st_r.man_prev && !man_on) begin
            st_nxt.target = st_r.dac;
            eff_tgt = st_r.dac;
        end

        // Background ramp, one step per tick
        tgt_acc = code_to_acc(eff_tgt);
        step = step_of(st_r.slope_work);
        is_step = (st_r.slope_work == SLOPE_STEP);
        if (tick) begin
            st_nxt.dac_strobe = 1'b1;
            if (st_r.acc < tgt_acc && !st_r.in_sync[IN_LIM_HI]) begin
                if (is_step || (tgt_acc - st_r.acc) <= step) begin
                    st_nxt.acc = tgt_acc;
                end else begin
                    st_nxt.acc = st_r.acc + step;
                end
            end else if (st_r.acc > tgt_acc && !st_r.in_sync[IN_LIM_LO]) begin
                if (is_step || (st_r.acc - tgt_acc) <= step) begin
                    st_nxt.acc = tgt_acc;
                end else begin
                    st_nxt.acc = st_r.acc - step;
                end
            end
            st_nxt.dac = round_code(st_nxt.acc);
        end

        // Register writes act at the edge that completes the transfer
        if (take) begin
            case (address)
                OFS_CTRL: begin
                    st_nxt.we = writedata[CTRL_WE_BIT];
                    if (writedata[CTRL_RESET_BIT]) begin
                        st_nxt.slope_work = st_r.slope_stored;
                        st_nxt.target = st_r.dac;
                        st_nxt.acc = code_to_acc(st_r.dac);
                        st_nxt.dac = st_r.dac;
                    end
                end
                OFS_TARGET: st_nxt.target = writedata[DAC_W-1:0];
                OFS_SLOPE_TEMP, OFS_SLOPE_PERSIST: begin
                    // Write enable is one-shot, as for every protected write
                    st_nxt.we = 1'b0;
                    if (st_r.we && slope_ok(writedata)) begin
                        st_nxt.slope_work = writedata[SLOPE_W-1:0];
                        if (address == OFS_SLOPE_PERSIST) begin
                            st_nxt.slope_stored = writedata[SLOPE_W-1:0];
                        end
                    end else begin
                        st_nxt.refused = 1'b1;
                    end
                end
                OFS_STATUS: begin
                    if (writedata[ST_REFUSED_BIT]) begin
                        st_nxt.refused = 1'b0;
                    end
                end
                OFS_WDOG_PRESET: st_nxt.wdog_preset = writedata[PRESET_W-1:0];
                OFS_START_VALUE: st_nxt.start_val = writedata[DAC_W-1:0];
                default: st_nxt.we = st_r.we;
            endcase
        end

        // Watchdog counts ticks; preset of zero disables it
        if (access) begin
            st_nxt.wdog_cnt = '0;
            st_nxt.wdog_fired = 1'b0;
        end else if (tick && st_r.wdog_preset != 8'h00 && !st_r.wdog_fired) begin
            st_nxt.wdog_cnt = st_r.wdog_cnt + 32'h0000_0001;
            if (st_nxt.wdog_cnt >= WDOG_W'(st_r.wdog_preset * WDOG_PER_MIN)) begin
                st_nxt.target = st_r.start_val;
                st_nxt.wdog_fired = 1'b1;
            end
        end

        // Done only when the accumulator rests exactly on the host target
        st_nxt.done = (st_nxt.acc == code_to_acc(st_nxt.target));
    end

    // Stored slope stands in for nonvolatile storage and powers up at its default
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r.waitreq <= 1'b1;
            st_r.rdata <= 32'h0000_0000;
            st_r.tick_cnt <= '0;
            st_r.in_meta <= '0;
            st_r.in_sync <= '0;
            st_r.man_prev <= 1'b0;
            st_r.we <= 1'b0;
            st_r.refused <= 1'b0;
            st_r.wdog_fired <= 1'b0;
            st_r.wdog_cnt <= '0;
            st_r.wdog_preset <= WDOG_PRESET_RESET;
            st_r.start_val <= START_RESET;
            st_r.slope_work <= SLOPE_RESET;
            st_r.slope_stored <= SLOPE_RESET;
            st_r.target <= START_RESET;
            st_r.acc <= {START_RESET, FRAC_ZERO};
            st_r.dac <= START_RESET;
            st_r.dac_strobe <= 1'b0;
            st_r.done <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign readdata = st_r.rdata;
    assign waitrequest = st_r.waitreq;
    assign dac_code = st_r.dac;
    assign dac_update = st_r.dac_strobe;
    assign at_target = st_r.done;
endmodule : slew_ramp_ctrl

// ===== verification/host_bus_master.sv
// Purpose: Host-side model that issues register commands over Avalon-MM.
// Assumes: Slave answers by dropping waitrequest; the bench timeout ends any hang.
// Notes: Signals change only by NBA just after a rising edge.
`timescale 1ns/1ns
module host_bus_master (
    // Clock and slave answer
    input wire logic clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    // Request
    output logic [5:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata
);
    initial begin
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
    end

    // One idle edge between transfers so a held request is never taken twice
    task automatic xfer(input logic rw, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !rw;
        write <= rw;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : xfer
endmodule : host_bus_master

// ===== verification/slew_ramp_monitor.sv
// Purpose: Port-level assertions for the slew-rate ramp controller.
// Assumes: Single clock domain, reset active high.
// Notes: Tick spacing is tracked by a small counter instead of long delays.
`timescale 1ns/1ns
module slew_ramp_monitor
    import ramp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DOC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Pins and converter
    input wire logic man_up,
    input wire logic man_dn,
    input wire logic lim_hi,
    input wire logic lim_lo,
    input wire logic [DAC_W-1:0] dac_code,
    input wire logic dac_update,
    input wire logic at_target
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    int gap_r;
    logic seen_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_r <= 0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= dac_update ? 0 : gap_r + 1;
            seen_r <= seen_r | dac_update;
        end
    end

    chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered in one cycle");
    chk_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_cause: assert property (!waitrequest |-> $past(read || write))
        else $error("answer without a request");
    chk_rdata_stands: assert property ($changed(readdata) |-> !waitrequest)
        else $error("read data changed outside an answer");
    chk_code_on_tick: assert property ($changed(dac_code) |-> dac_update)
        else $error("converter code changed off a tick");
    chk_tick_period: assert property (dac_update && seen_r |-> gap_r == TICK_CYCLES - 1)
        else $error("tick spacing wrong");
    chk_tick_due: assert property (seen_r |-> gap_r < TICK_CYCLES)
        else $error("tick overdue");
    chk_manual_down: assert property (dac_update && man_dn && $past(man_dn, 3) && !man_up
        && !lim_lo |-> dac_code <= $past(dac_code)) else $error("manual down moved upward");
    chk_limit_low: assert property (dac_update && lim_lo && $past(lim_lo, 3)
        |-> dac_code >= $past(dac_code)) else $error("low limit passed");
endmodule : slew_ramp_monitor

bind slew_ramp_ctrl slew_ramp_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .man_up(man_up), .man_dn(man_dn),
    .lim_hi(lim_hi), .lim_lo(lim_lo), .dac_code(dac_code), .dac_update(dac_update),
    .at_target(at_target));

// ===== verification/dac_slew_rate_ramp_control_test.sv
// Purpose: Self-checking bench for the slew-rate ramp controller.
// Assumes: Tick of 20 clocks and a watchdog minute of 10 ticks.
// Notes: Expected codes are rebuilt from the slope gain, never read from the design.
`timescale 1ns/1ns
module dac_slew_rate_ramp_control_test;
    import ramp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic man_up = 1'b0;
    logic man_dn = 1'b0;
    logic lim_hi = 1'b0;
    logic lim_lo = 1'b0;
    logic [5:0] address;
    logic read, write, waitrequest, dac_update, at_target;
    logic [31:0] writedata, readdata, q;
    logic [DAC_W-1:0] dac_code;
    logic [15:0] seed_r = 16'h0030;
    logic [SLOPE_W-1:0] slope, stored;
    int fail_count = 0;
    int num_checks = 0;

    always #25 clk = ~clk;

    slew_ramp_ctrl #(.TICK_CYCLES(20), .WDOG_TICKS_PER_MIN(10)) DUT (.clk(clk), .rst(rst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .man_up(man_up), .man_dn(man_dn),
        .lim_hi(lim_hi), .lim_lo(lim_lo), .dac_code(dac_code), .dac_update(dac_update),
        .at_target(at_target));
    host_bus_master host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(read), .write(write), .writedata(writedata));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [DAC_W-1:0] ramp_code(input longint c, input longint n,
        input longint s);
        longint a;
        a = (c <<< FRAC_W) + n * ((s * longint'(SLOPE_GAIN)) >>> GAIN_SHIFT);
        return DAC_W'((a + longint'(ROUND_HALF)) >>> FRAC_W);
    endfunction : ramp_code

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h00000000, q);
        check(q, exp);
    endtask : rd

    // Sampled one ns after the edge so the tick edge's updates have landed
    task automatic ticks(input int n);
        int k;
        k = 0;
        while (k < n) begin
            @(posedge clk);
            #1;
            if (dac_update === 1'b1) k++;
        end
    endtask : ticks

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end

    initial begin
        stored = SLOPE_RESET;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_WORK_SLOPE, SLOPE_RESET);
        rd(OFS_STORED_SLOPE, SLOPE_RESET);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_SLOPE_TEMP, 32'h5);
        rd(OFS_STATUS, 32'h3);
        wr(OFS_STATUS, 32'h2);
        rd(OFS_WORK_SLOPE, SLOPE_RESET);
        rd(6'h3C, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed_r = lfsr(seed_r);
            slope = {8'h00, seed_r} + 24'h000001;
            wr(OFS_CTRL, 32'h1);
            wr(i[0] ? OFS_SLOPE_PERSIST : OFS_SLOPE_TEMP, {8'h00, slope});
            if (i[0]) stored = slope;
            rd(OFS_WORK_SLOPE, {8'h00, slope});
            rd(OFS_STORED_SLOPE, {8'h00, stored});
        end
        wr(OFS_CTRL, 32'h1);
        wr(OFS_SLOPE_TEMP, 32'h00989680);
        rd(OFS_STATUS, 32'h3);
        wr(OFS_STATUS, 32'h2);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_SLOPE_TEMP, 32'h00000123);
        wr(OFS_CTRL, 32'h2);
        rd(OFS_WORK_SLOPE, {8'h00, stored});
        wr(OFS_CTRL, 32'h1);
        wr(OFS_SLOPE_PERSIST, SLOPE_RESET);
        ticks(1);
        wr(OFS_TARGET, 32'h100);
        for (int n = 1; n <= 5; n++) begin
            ticks(1);
            check(dac_code, ramp_code(0, n, SLOPE_RESET));
        end
        rd(OFS_DAC_CODE, ramp_code(0, 5, SLOPE_RESET));
        wr(OFS_TARGET, 32'h0);
        ticks(8);
        check(dac_code, 32'h0);
        wr(OFS_TARGET, 32'hFFF);
        ticks(2);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_SLOPE_TEMP, SLOPE_STEP);
        ticks(2);
        check(dac_code, 32'hFFF);
        check(at_target, 1'b1);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_SLOPE_TEMP, SLOPE_RESET);
        ticks(1);
        wr(OFS_TARGET, 32'h0);
        ticks(3);
        check(dac_code, ramp_code(12'hFFF, -3, SLOPE_RESET));
        wr(OFS_CTRL, 32'h2);
        ticks(3);
        check(dac_code, ramp_code(12'hFFF, -3, SLOPE_RESET));
        @(posedge clk);
        man_dn <= 1'b1;
        ticks(4);
        check(dac_code < 12'hFFE, 1'b1);
        @(posedge clk);
        lim_lo <= 1'b1;
        ticks(3);
        @(posedge clk);
        man_dn <= 1'b0;
        lim_lo <= 1'b0;
        wr(OFS_START_VALUE, 32'h0A5);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_SLOPE_PERSIST, SLOPE_STEP);
        wr(OFS_WDOG_PRESET, 32'h1);
        rd(OFS_WDOG_PRESET, 32'h1);
        rd(OFS_START_VALUE, 32'h0A5);
        wr(OFS_TARGET, 32'h300);
        repeat (4) begin
            ticks(6);
            rd(OFS_TARGET, 32'h300);
        end
        check(dac_code, 32'h300);
        ticks(15);
        check(dac_code, 32'h0A5);
        rd(OFS_STATUS, 32'h5);
        summarize();
    end
endmodule : dac_slew_rate_ramp_control_test
